// >>> rtl/data_parity_error_capture.sv
// Data parity error checker and capture registers of the processor bus bridge.
// What this block does
// RULE_01: The bus address of the transaction with the latest logged parity error is captured.
// RULE_02: The upper data half seen when a parity error is logged is captured.
// RULE_03: The lower data half seen when a parity error is logged is captured.
// RULE_04: Captures load only when the error-logged flag goes from 0 to 1, never while it is set.
// RULE_05: With check-all on, parity is checked on every acknowledged bus cycle.
// RULE_06: With check-all off, parity is checked only on acknowledged writes to this device.
// RULE_07: With machine-check enable cleared, no machine check request comes from the flag.
// RULE_08: Each of eight invert bits inverts the parity driven on its byte lane during reads.
// RULE_09: Captures hold after the flag is cleared until it next rises, and ignore writes.
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none

module data_parity_error_capture (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        srst,
  // Processor bus, sampled on the bridge clock
  input  wire logic [31:0] busAddress,
  input  wire logic [31:0] busDataHigh,
  input  wire logic [31:0] busDataLow,
  input  wire logic [7:0]  byteLaneParityIn,
  input  wire logic        transferAcknowledgeN,
  input  wire logic        busWrite,
  input  wire logic        deviceSelected,
  // Read data driven by the bridge and its parity
  input  wire logic [31:0] readDataHigh,
  input  wire logic [31:0] readDataLow,
  input  wire logic        readDrive,
  output var  logic [7:0]  byteLaneParityOut,
  output var  logic        byteLaneParityOe,
  // Controls from the neighbouring control register
  input  wire logic        checkAll,
  input  wire logic        machineCheckEnable,
  input  wire logic [7:0]  parityInvertBits,
  input  wire logic        clearErrorLog,
  // Status
  output var  logic        errorLogged,
  output var  logic        machineCheckRequestN,
  // Register port
  input  wire logic [31:0] regAddr,
  input  wire logic [31:0] regWdata,
  input  wire logic        regWrite,
  input  wire logic        regRead,
  output var  logic [31:0] regRdata
);

  localparam int unsigned LANES  = parity_capture_pkg::LANES;
  localparam int unsigned LANE_W = parity_capture_pkg::LANE_W;
  localparam int unsigned DATA_W = parity_capture_pkg::DATA_W;

  logic [DATA_W-1:0] snoopBus;
  logic [DATA_W-1:0] driveBus;
  logic [LANES-1:0]  laneErr;
  logic [LANES-1:0]  laneParity;
  logic              checkCycle;
  logic              parityError;
  logic              logRise;

  logic              errorLogged_d;
  logic              errorLogged_q;
  logic              mchkN_d;
  logic              mchkN_q;
  logic [LANES-1:0]  parityOut_d;
  logic [LANES-1:0]  parityOut_q;
  logic              parityOe_d;
  logic              parityOe_q;
  logic [31:0]       rdata_d;
  logic [31:0]       rdata_q;

  logic [31:0]       capAddress;
  logic [31:0]       capDataHigh;
  logic [31:0]       capDataLow;

  // Lane 0 covers the most significant byte of the upper half, lane 7 the least of the lower.
  assign snoopBus = {busDataHigh, busDataLow};
  assign driveBus = {readDataHigh, readDataLow};

  genvar g;
  generate
    for (g = 0; g < LANES; g++) begin : gLane
      parity_lane #(
        .WIDTH (LANE_W),
        .ODD   (parity_capture_pkg::ODD_PARITY)
      ) uLane (
        .checkData   (snoopBus[DATA_W-1-g*LANE_W -: LANE_W]),
        .checkParity (byteLaneParityIn[g]),
        .driveData   (driveBus[DATA_W-1-g*LANE_W -: LANE_W]),
        .invert      (parityInvertBits[g]), // RULE_08
        .laneError   (laneErr[g]),
        .driveParity (laneParity[g])
      );
    end
  endgenerate

  // Check scope and error logging.
  always_comb begin
    checkCycle = !transferAcknowledgeN &&
                 (checkAll ||                      // RULE_05
                  (busWrite && deviceSelected));   // RULE_06
    parityError = checkCycle && (|laneErr);
    // Captures load only on the edge of the flag; a set flag blocks them.
    logRise = parityError && !errorLogged_q;       // RULE_04
    // A new error wins over a clear arriving in the same cycle.
    errorLogged_d = parityError || (errorLogged_q && !clearErrorLog);
    // One-cycle active-low machine check pulse when the flag rises.
    mchkN_d = !(logRise && machineCheckEnable);    // RULE_07
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      errorLogged_q <= 1'b0;
      mchkN_q       <= parity_capture_pkg::MCHK_IDLE;
    end else begin
      errorLogged_q <= errorLogged_d;
      mchkN_q       <= mchkN_d;
    end
  end

  assign errorLogged          = errorLogged_q;
  assign machineCheckRequestN = mchkN_q;

  // Capture registers; register writes never reach them.
  capture_reg #(
    .WIDTH       (32),
    .RESET_VALUE (parity_capture_pkg::CAPTURE_RESET)
  ) uCapAddress (
    .clk  (clk),
    .srst (srst),
    .load (logRise),      // RULE_01
    .din  (busAddress),
    .dout (capAddress)
  );

  capture_reg #(
    .WIDTH       (32),
    .RESET_VALUE (parity_capture_pkg::CAPTURE_RESET)
  ) uCapDataHigh (
    .clk  (clk),
    .srst (srst),
    .load (logRise),      // RULE_02
    .din  (busDataHigh),
    .dout (capDataHigh)
  );

  capture_reg #(
    .WIDTH       (32),
    .RESET_VALUE (parity_capture_pkg::CAPTURE_RESET)
  ) uCapDataLow (
    .clk  (clk),
    .srst (srst),
    .load (logRise),      // RULE_03
    .din  (busDataLow),
    .dout (capDataLow)
  );

  // Read parity lines, registered to match read data held one cycle.
  always_comb begin
    parityOe_d  = readDrive;
    parityOut_d = readDrive ? laneParity : parity_capture_pkg::PARITY_RESET; // RULE_08
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      parityOe_q  <= 1'b0;
      parityOut_q <= parity_capture_pkg::PARITY_RESET;
    end else begin
      parityOe_q  <= parityOe_d;
      parityOut_q <= parityOut_d;
    end
  end

  assign byteLaneParityOut = parityOut_q;
  assign byteLaneParityOe  = parityOe_q;

  // Register read mux; data stand only in the cycle after the strobe.
  always_comb begin
    rdata_d = parity_capture_pkg::READ_IDLE;
    if (regRead) begin
      unique case (regAddr)
        parity_capture_pkg::ADDR_ERROR_ADDRESS:   rdata_d = capAddress;
        parity_capture_pkg::ADDR_ERROR_DATA_HIGH: rdata_d = capDataHigh;
        parity_capture_pkg::ADDR_ERROR_DATA_LOW:  rdata_d = capDataLow;
        default:                                  rdata_d = parity_capture_pkg::READ_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      rdata_q <= parity_capture_pkg::READ_IDLE;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign regRdata = rdata_q;

  // Checking logic.
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  logic [LANES-1:0] refReadParity;
  logic             refLaneErr;

  always_comb begin
    refLaneErr = 1'b0;
    for (int i = 0; i < LANES; i++) begin
      refReadParity[i] = ~(^driveBus[DATA_W-1-i*LANE_W -: LANE_W]) ^ parityInvertBits[i];
      refLaneErr = refLaneErr ||
                   (byteLaneParityIn[i] != ~(^snoopBus[DATA_W-1-i*LANE_W -: LANE_W]));
    end
  end

  sequence sErrorOnClearFlag;
    !errorLogged_q && !transferAcknowledgeN && checkAll && refLaneErr;
  endsequence

  sequence sMachinePulse;
    !machineCheckRequestN ##1 machineCheckRequestN;
  endsequence

  a_address_captured: assert property ( // RULE_01
    sErrorOnClearFlag |=> (capAddress == $past(busAddress)) && errorLogged_q)
    else $error("Error address not captured on flag rise.");

  a_data_high_read: assert property ( // RULE_02
    logRise ##1 (regRead && regAddr == parity_capture_pkg::ADDR_ERROR_DATA_HIGH && !logRise)
      |=> regRdata == $past(busDataHigh, 2))
    else $error("Upper error data does not read back as captured.");

  a_data_low_read: assert property ( // RULE_03
    logRise ##1 (regRead && regAddr == parity_capture_pkg::ADDR_ERROR_DATA_LOW && !logRise)
      |=> regRdata == $past(busDataLow, 2))
    else $error("Lower error data does not read back as captured.");

  a_hold_while_set: assert property ( // RULE_04
    errorLogged_q |=> $stable(capAddress) && $stable(capDataHigh) && $stable(capDataLow))
    else $error("Capture changed while the flag was already set.");

  a_check_all_scope: assert property ( // RULE_05
    sErrorOnClearFlag |=> errorLogged_q ##0 (capDataLow == $past(busDataLow)))
    else $error("Error on acknowledged cycle missed with check-all on.");

  a_write_only_scope: assert property ( // RULE_06
    (!checkAll && !(busWrite && deviceSelected)) |-> !parityError)
    else $error("Parity checked outside writes to the device with check-all off.");

  a_mchk_disabled: assert property ( // RULE_07
    !machineCheckEnable |=> machineCheckRequestN)
    else $error("Machine check requested while disabled.");

  a_mchk_pulse: assert property ( // RULE_07
    (logRise && machineCheckEnable) |=> sMachinePulse)
    else $error("Machine check pulse missing or not one cycle long.");

  a_read_parity: assert property ( // RULE_08
    readDrive |=> byteLaneParityOe && (byteLaneParityOut == $past(refReadParity)))
    else $error("Driven read parity does not follow data and invert bits.");

  a_hold_after_clear: assert property ( // RULE_09
    (!logRise || regWrite) && !logRise |=> $stable(capAddress) && $stable(capDataHigh)
                                            && $stable(capDataLow))
    else $error("Capture changed without a flag rise.");

  a_read_one_cycle: assert property (
    !regRead |=> regRdata == parity_capture_pkg::READ_IDLE)
    else $error("Read data present outside the cycle after a read strobe.");

  a_capture_on_rise: assert property ( // RULE_01
    logRise |=> (capAddress == $past(busAddress)) && (capDataHigh == $past(busDataHigh))
                && (capDataLow == $past(busDataLow)))
    else $error("Captures did not load together on the flag rise.");

  a_flag_sets: assert property ( // RULE_05
    parityError |=> errorLogged_q)
    else $error("Checked parity error did not set the flag.");

  a_flag_needs_error: assert property ( // RULE_04
    (!errorLogged_q && !parityError) |=> !errorLogged_q)
    else $error("Flag rose without a checked parity error.");

  a_flag_clears: assert property (
    (errorLogged_q && clearErrorLog && !parityError) |=> !errorLogged_q)
    else $error("Flag did not clear on request.");

  a_no_pulse_set: assert property ( // RULE_04
    errorLogged_q |=> machineCheckRequestN)
    else $error("Machine check pulsed while the flag was already set.");

  a_mchk_needs_rise: assert property ( // RULE_07
    !(logRise && machineCheckEnable) |=> machineCheckRequestN)
    else $error("Machine check requested without an enabled flag rise.");

  a_parity_idle: assert property ( // RULE_08
    !readDrive |=> !byteLaneParityOe && (byteLaneParityOut == parity_capture_pkg::PARITY_RESET))
    else $error("Read parity driven while no read data is driven.");

  a_write_ignored: assert property ( // RULE_09
    (regWrite && !logRise && (regWdata != capAddress)) |=> capAddress != $past(regWdata))
    else $error("Register write reached the captured address.");

endmodule

`default_nettype wire

// >>> common/parity_capture_pkg.sv
// Shared constants for the data parity error capture block.
package parity_capture_pkg;

  // Register byte addresses on the register port.
  localparam logic [31:0] ADDR_ERROR_ADDRESS   = 32'hFEF8_0070;
  localparam logic [31:0] ADDR_ERROR_DATA_HIGH = 32'hFEF8_0078;
  localparam logic [31:0] ADDR_ERROR_DATA_LOW  = 32'hFEF8_0080;

  // Widths of the processor bus and of the register port.
  localparam int unsigned ADDR_W    = 32;
  localparam int unsigned HALF_W    = 32;
  localparam int unsigned DATA_W    = 64;
  localparam int unsigned LANE_W    = 8;
  localparam int unsigned LANES     = 8;

  // Reset values.
  localparam logic [31:0] CAPTURE_RESET = 32'h0000_0000;
  localparam logic [31:0] READ_IDLE     = 32'h0000_0000;
  localparam logic [7:0]  PARITY_RESET  = 8'h00;

  // Correct parity is odd: a lane plus its parity bit holds an odd count of ones.
  localparam logic ODD_PARITY = 1'b1;

  // Level of the active-low machine check request when idle.
  localparam logic MCHK_IDLE = 1'b1;

endpackage

// >>> rtl/capture_reg.sv
// Loadable read-only capture register with synchronous reset.
`timescale 1ns/1ps
`default_nettype none

module capture_reg #(
  parameter int unsigned       WIDTH       = 32,
  parameter logic [WIDTH-1:0]  RESET_VALUE = '0
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             srst,
  // Load port
  input  wire logic             load,
  input  wire logic [WIDTH-1:0] din,
  // Held value
  output var  logic [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] value_d;
  logic [WIDTH-1:0] value_q;

  always_comb begin
    value_d = value_q;
    if (load) begin
      value_d = din;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      value_q <= RESET_VALUE;
    end else begin
      value_q <= value_d;
    end
  end

  assign dout = value_q;

endmodule

`default_nettype wire

// >>> rtl/parity_lane.sv
// One byte lane: parity check of snooped data and parity generation for read data.
`timescale 1ns/1ps
`default_nettype none

module parity_lane #(
  parameter int unsigned WIDTH = 8,
  parameter logic        ODD   = 1'b1
) (
  // Snooped lane
  input  wire logic [WIDTH-1:0] checkData,
  input  wire logic             checkParity,
  // Driven lane
  input  wire logic [WIDTH-1:0] driveData,
  input  wire logic             invert,
  // Results
  output var  logic             laneError,
  output var  logic             driveParity
);

  logic expectCheck;
  logic expectDrive;

  always_comb begin
    expectCheck = (^checkData) ^ ODD;
    expectDrive = (^driveData) ^ ODD;
    laneError   = checkParity ^ expectCheck;
    // An inverting bit forces a wrong parity on this lane for testing.
    driveParity = expectDrive ^ invert;
  end

endmodule

`default_nettype wire

// >>> verification/host_bus_model.sv
// Host bus master model that drives acknowledged processor bus beats.
`timescale 1ns/1ps
`default_nettype none
module host_bus_model (
  // Clock
  input  wire logic        clk,
  // Processor bus
  output var  logic [31:0] busAddress,
  output var  logic [31:0] busDataHigh,
  output var  logic [31:0] busDataLow,
  output var  logic [7:0]  parity,
  output var  logic        ackN,
  output var  logic        busWrite,
  output var  logic        selected
);
  initial begin
    {busAddress, busDataHigh, busDataLow, parity} = '0;
    {ackN, busWrite, selected} = 3'b100;
  end
  // Once released, address, data and parity show inverted values so stale data is never mistaken for valid.
  task automatic beat(input logic [31:0] a, input logic [63:0] d,
                      input logic [7:0] p, input logic w, input logic s);
    @(posedge clk);
    busAddress <= a;
    {busDataHigh, busDataLow} <= d;
    parity <= p;
    busWrite <= w;
    selected <= s;
    ackN <= 1'b0;
    @(posedge clk);
    ackN <= 1'b1;
    busAddress <= ~a;
    {busDataHigh, busDataLow} <= ~d;
    parity <= ~p;
  endtask
endmodule
`default_nettype wire

// >>> verification/test_data_parity_error_capture.sv
// Self-checking bench for the parity error capture block.
`timescale 1ns/1ps
`default_nettype none
module test_data_parity_error_capture;
  logic        clk, srst, checkAll, mce, clr, readDrive, regWrite, regRead;
  logic        ackN, busWrite, sel, pOe, flag, mchkN;
  logic [7:0]  inv, par, pOut;
  logic [31:0] bA, bH, bL, rH, rL, regAddr, regWdata, regRdata;
  int          nFail, checkCount;
  localparam logic [31:0] A1 = 32'h1234_5678;
  localparam logic [63:0] D1 = 64'hA5A5_0F0F_3C3C_8001;

  host_bus_model i_host_bus_model (.clk(clk), .busAddress(bA), .busDataHigh(bH),
    .busDataLow(bL), .parity(par), .ackN(ackN), .busWrite(busWrite), .selected(sel));
  data_parity_error_capture i_data_parity_error_capture (.clk(clk), .srst(srst),
    .busAddress(bA), .busDataHigh(bH), .busDataLow(bL), .byteLaneParityIn(par),
    .transferAcknowledgeN(ackN), .busWrite(busWrite), .deviceSelected(sel),
    .readDataHigh(rH), .readDataLow(rL), .readDrive(readDrive),
    .byteLaneParityOut(pOut), .byteLaneParityOe(pOe), .checkAll(checkAll),
    .machineCheckEnable(mce), .parityInvertBits(inv), .clearErrorLog(clr),
    .errorLogged(flag), .machineCheckRequestN(mchkN), .regAddr(regAddr),
    .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  function automatic logic [7:0] oddPar(input logic [63:0] d);
    for (int i = 0; i < 8; i++) oddPar[i] = ~^d[63-8*i -: 8];
  endfunction

  task automatic chk(input string n, input logic [63:0] s, input logic [63:0] e);
    checkCount++;
    if (s !== e) begin
      nFail++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checkCount, nFail);
    if (nFail == 0 && checkCount > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    @(posedge clk);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRead <= 1'b0;
    #1 chk("regRdata", regRdata, e);
  endtask

  task automatic rd3(input logic [31:0] a, input logic [63:0] d);
    rd(parity_capture_pkg::ADDR_ERROR_ADDRESS, a);
    rd(parity_capture_pkg::ADDR_ERROR_DATA_HIGH, d[63:32]);
    rd(parity_capture_pkg::ADDR_ERROR_DATA_LOW, d[31:0]);
  endtask

  task automatic t_reset;
    rd3(32'h0, 64'h0);
    rd(32'hFEF8_0074, 32'h0);
    @(posedge clk);
    #1 chk("regRdata idle", regRdata, 32'h0);
    chk("mchkN", mchkN, 1'b1);
  endtask

  task automatic t_capture;
    i_host_bus_model.beat(A1, D1, oddPar(D1) ^ 8'h10, 1'b1, 1'b1);
    regRead <= 1'b1;
    regAddr <= parity_capture_pkg::ADDR_ERROR_DATA_HIGH;
    #1 chk("flag", flag, 1'b1);
    chk("mchkN", mchkN, 1'b0);
    @(posedge clk);
    regRead <= 1'b0;
    #1 chk("mchkN", mchkN, 1'b1);
    chk("regRdata", regRdata, D1[63:32]);
    rd3(A1, D1);
  endtask

  task automatic t_hold;
    i_host_bus_model.beat(~A1, ~D1, 8'h00, 1'b1, 1'b1);
    #1 chk("mchkN", mchkN, 1'b1);
    rd3(A1, D1);
    @(posedge clk);
    regWrite <= 1'b1;
    regAddr <= parity_capture_pkg::ADDR_ERROR_ADDRESS;
    regWdata <= 32'hFFFF_FFFF;
    @(posedge clk);
    regWrite <= 1'b0;
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    #1 chk("flag", flag, 1'b0);
    rd3(A1, D1);
  endtask

  task automatic t_scope;
    i_host_bus_model.beat(32'h0BAD_0001, D1, ~oddPar(D1), 1'b0, 1'b1);
    i_host_bus_model.beat(32'h0BAD_0002, D1, ~oddPar(D1), 1'b1, 1'b0);
    i_host_bus_model.beat(32'h0BAD_0003, ~D1, oddPar(~D1), 1'b1, 1'b1);
    #1 chk("flag", flag, 1'b0);
    checkAll <= 1'b1;
    mce <= 1'b0;
    i_host_bus_model.beat(32'h00C0_FFEE, ~D1, 8'h00, 1'b0, 1'b0);
    regRead <= 1'b1;
    regAddr <= parity_capture_pkg::ADDR_ERROR_DATA_LOW;
    #1 chk("flag", flag, 1'b1);
    chk("mchkN", mchkN, 1'b1);
    @(posedge clk);
    regRead <= 1'b0;
    #1 chk("regRdata", regRdata, 32'(~D1[31:0]));
    rd3(32'h00C0_FFEE, ~D1);
  endtask

  task automatic t_invert;
    logic [63:0] d;
    for (int i = 0; i < 9; i++) begin
      d = 64'h0123_4567_89AB_CDEF + 64'(i);
      @(posedge clk);
      {rH, rL} <= d;
      inv <= (i < 8) ? 8'(1 << i) : 8'h00;
      readDrive <= 1'b1;
      @(posedge clk);
      readDrive <= 1'b0;
      #1 chk("pOut", pOut, oddPar(d) ^ ((i < 8) ? 8'(1 << i) : 8'h00));
      chk("pOe", pOe, 1'b1);
    end
    @(posedge clk);
    #1 chk("pOe", pOe, 1'b0);
  endtask

  initial begin
    #50000;
    nFail++;
    end_of_test;
  end

  initial begin
    {srst, checkAll, mce, clr, readDrive, regWrite, regRead} = 7'b1010000;
    {inv, rH, rL, regAddr, regWdata} = '0;
    nFail = 0;
    checkCount = 0;
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    t_reset;
    t_capture;
    t_hold;
    t_scope;
    t_invert;
    end_of_test;
  end
endmodule
`default_nettype wire
